// ### pps_sync_top.sv
`timescale 1ns/10ps
module pps_sync_top
   import pps_sync_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // pulse pins
   input wire logic sync_in_line,
   input wire logic shared_pulse_line_in,
   output logic shared_pulse_line_out,
   output logic shared_pulse_line_oe,
   // general purpose trigger pins
   input wire logic [N_TRIG-1:0] gp_trigger_in,
   // status and event pulses
   output mode_t pps_mode,
   output logic pps_arrived_evt,
   output logic pps_lost_evt,
   output logic pps_found_evt,
   output logic [N_TRIG-1:0] gp_trigger_event
);
   // bus state
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [7:0] awaddr_q_r, awaddr_q_nxt;
   logic [31:0] wdata_q_r, wdata_q_nxt;
   logic [3:0] wstrb_q_r, wstrb_q_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_fire;
   logic [31:0] wmask;
   // device state
   logic [10:0] div_r, div_nxt;
   logic [15:0] subsec_r, subsec_nxt, thresh_r, thresh_nxt;
   logic [31:0] sec_r, sec_nxt;
   logic [17:0] since_r, since_nxt;
   logic src_r, src_nxt, oe_r, oe_nxt;
   logic [23:0] stamp_r, stamp_nxt;
   logic [N_TRIG-1:0] level_r, level_nxt, en_r, en_nxt;
   logic [15:0] status_r, status_nxt;
   mode_t mode_r, mode_nxt;
   logic pulse_out_r, pulse_out_nxt, line_oe_r, line_oe_nxt;
   logic arrived_r, arrived_nxt, lost_r, lost_nxt, found_r, found_nxt;
   logic [N_TRIG-1:0] trig_evt_r, trig_evt_nxt;
   // pins
   logic [N_PINS-1:0] pins_s, pins_rise, pins_fall;
   logic tick, pulse_rise, in_window;
   logic [17:0] win_lo, win_hi;

   // every pin is synchronised before use
   pin_sync2 #(.W(N_PINS)) i_pin_sync2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({gp_trigger_in, shared_pulse_line_in, sync_in_line}),
      .q(pins_s)
   );

   edge_detect #(.W(N_PINS)) i_edge_detect (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pins_s),
      .rise(pins_rise),
      .fall(pins_fall)
   );

   // byte mask from the held strobes
   assign wmask = {{8{wstrb_q_r[3]}}, {8{wstrb_q_r[2]}},
                   {8{wstrb_q_r[1]}}, {8{wstrb_q_r[0]}}};
   assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFS_CTRL) || (a == OFS_THRESH) || (a == OFS_SEC) ||
                (a == OFS_SUBSEC) || (a == OFS_STATUS) ||
                (a == OFS_ARRIVE) || (a == OFS_TRIG_LEVEL) ||
                (a == OFS_TRIG_EN);
   endfunction : addr_ok

   // axi4-lite handshakes; one write and one read at a time
   always_comb
   begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      awaddr_q_nxt = awaddr_q_r;
      wdata_q_nxt = wdata_q_r;
      wstrb_q_nxt = wstrb_q_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (awvalid && awready_r)
      begin
         aw_hold_nxt = 1'b1;
         awaddr_q_nxt = awaddr;
      end
      if (wvalid && wready_r)
      begin
         w_hold_nxt = 1'b1;
         wdata_q_nxt = wdata;
         wstrb_q_nxt = wstrb;
      end
      if (wr_fire)
      begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = addr_ok(awaddr_q_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && bready)
         bvalid_nxt = 1'b0;
      if (arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (araddr)
            OFS_CTRL: rdata_nxt = {30'h0, oe_r, src_r};
            OFS_THRESH: rdata_nxt = {16'h0000, thresh_r};
            OFS_SEC: rdata_nxt = sec_r;
            OFS_SUBSEC: rdata_nxt = {16'h0000, subsec_r};
            OFS_STATUS: rdata_nxt = {16'h0000, status_r};
            OFS_ARRIVE: rdata_nxt = {8'h00, stamp_r};
            OFS_TRIG_LEVEL: rdata_nxt = {24'h000000, level_r};
            OFS_TRIG_EN: rdata_nxt = {24'h000000, en_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      if (rvalid_r && rready)
         rvalid_nxt = 1'b0;
      // ready drops while a channel is held or answering
      awready_nxt = !aw_hold_nxt && !bvalid_nxt;
      wready_nxt = !w_hold_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {aw_hold_r, w_hold_r, awready_r, wready_r} <= '0;
         {bvalid_r, arready_r, rvalid_r} <= '0;
         {awaddr_q_r, wdata_q_r, wstrb_q_r, rdata_r} <= '0;
         bresp_r <= RESP_OKAY;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awaddr_q_r <= awaddr_q_nxt;
         wdata_q_r <= wdata_q_nxt;
         wstrb_q_r <= wstrb_q_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // subsecond tick enable
   assign tick = (div_r == SUBSEC_CYC_M1);
   // both masters listen on sync input
   // otherwise shared line is the input
   assign pulse_rise = oe_r ? pins_rise[0] : pins_rise[1];
   // window edges, 18 bits so no wrap
   assign win_lo = SPAN_NOMINAL - {2'b00, thresh_r};
   assign win_hi = SPAN_NEXT + {2'b00, thresh_r};
   // zero gives 65535..65536, max accepts all
   assign in_window = (thresh_r == THRESH_ALL) ||
                      ((since_r >= win_lo) && (since_r <= win_hi));

   // time keeping, pulse checking and software writes
   always_comb
   begin
      div_nxt = tick ? DIV_ZERO : div_r + 11'h001;
      subsec_nxt = subsec_r;
      sec_nxt = sec_r;
      since_nxt = since_r;
      src_nxt = src_r;
      oe_nxt = oe_r;
      thresh_nxt = thresh_r;
      stamp_nxt = stamp_r;
      level_nxt = level_r;
      en_nxt = en_r;
      arrived_nxt = 1'b0;
      lost_nxt = 1'b0;
      found_nxt = 1'b0;
      // wrap of subseconds carries a second
      if (tick)
      begin
         subsec_nxt = subsec_r + 16'h0001;
         if (subsec_r == SUBSEC_MAX)
            sec_nxt = sec_r + 32'h00000001;
         if (since_r != SINCE_SAT)
            since_nxt = since_r + 18'h00001;
      end
      // control writes land before the hardware fallback
      if (wr_fire && awaddr_q_r == OFS_CTRL && wstrb_q_r[0])
      begin
         src_nxt = wdata_q_r[CTRL_SRC_BIT];
         oe_nxt = wdata_q_r[CTRL_OE_BIT];
      end
      if (wr_fire && awaddr_q_r == OFS_THRESH)
         thresh_nxt = (thresh_r & ~wmask[15:0]) |
                      (wdata_q_r[15:0] & wmask[15:0]);
      if (wr_fire && awaddr_q_r == OFS_TRIG_LEVEL && wstrb_q_r[0])
         level_nxt = wdata_q_r[N_TRIG-1:0];
      if (wr_fire && awaddr_q_r == OFS_TRIG_EN && wstrb_q_r[0])
         en_nxt = wdata_q_r[N_TRIG-1:0];
      if (src_r == SRC_EXTERNAL && thresh_r != THRESH_ALL &&
          since_r > win_hi)
      begin
         lost_nxt = 1'b1;
         src_nxt = SRC_INTERNAL;
      end
      if (pulse_rise)
      begin
         stamp_nxt = {sec_r[7:0], subsec_r};
         since_nxt = 18'h00000;
         if (src_r == SRC_INTERNAL)
            found_nxt = 1'b1;
         else if (in_window)
         begin
            arrived_nxt = 1'b1;
            subsec_nxt = 16'h0000;
            if (subsec_r[HALF_SEC_BIT])
               sec_nxt = sec_r + 32'h00000001;
         end
         else
         begin
            lost_nxt = 1'b1;
            src_nxt = SRC_INTERNAL;
         end
      end
      // counter writes add a two's complement difference
      if (wr_fire && awaddr_q_r == OFS_SEC)
         sec_nxt = sec_nxt + (wdata_q_r & wmask);
      if (wr_fire && awaddr_q_r == OFS_SUBSEC)
         subsec_nxt = subsec_nxt + (wdata_q_r[15:0] & wmask[15:0]);
      // one event per enabled trigger on its selected edge: falling if its level bit is set, else rising
      trig_evt_nxt = en_r & ((level_r & pins_fall[N_PINS-1:2]) |
                             (~level_r & pins_rise[N_PINS-1:2]));
      // sticky flags, the set wins over a clear
      status_nxt = status_r;
      if (wr_fire && awaddr_q_r == OFS_STATUS)
         status_nxt = status_r & ~(wdata_q_r[15:0] & wmask[15:0]);
      status_nxt[ST_ARRIVED] = status_nxt[ST_ARRIVED] | arrived_nxt;
      status_nxt[ST_LOST] = status_nxt[ST_LOST] | lost_nxt;
      status_nxt[ST_FOUND] = status_nxt[ST_FOUND] | found_nxt;
      status_nxt[ST_TRIG_LSB +: N_TRIG] =
         status_nxt[ST_TRIG_LSB +: N_TRIG] | trig_evt_nxt;
      unique case ({src_nxt, oe_nxt})
         {SRC_INTERNAL, 1'b0}: mode_nxt = MODE_FREE_RUN;
         {SRC_INTERNAL, 1'b1}: mode_nxt = MODE_MASTER;
         {SRC_EXTERNAL, 1'b1}: mode_nxt = MODE_SYNC_MASTER;
         {SRC_EXTERNAL, 1'b0}: mode_nxt = MODE_SLAVE;
      endcase
      // masters pulse at each second start
      line_oe_nxt = oe_nxt;
      pulse_out_nxt = oe_nxt && (subsec_nxt < PULSE_TICKS);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_r <= DIV_ZERO;
         {subsec_r, sec_r, since_r, stamp_r} <= '0;
         src_r <= SRC_INTERNAL;
         oe_r <= OE_RESET;
         thresh_r <= THRESH_RESET;
         {level_r, en_r, status_r, trig_evt_r} <= '0;
         mode_r <= MODE_FREE_RUN;
         {pulse_out_r, line_oe_r, arrived_r, lost_r, found_r} <= '0;
      end
      else
      begin
         div_r <= div_nxt;
         subsec_r <= subsec_nxt;
         sec_r <= sec_nxt;
         since_r <= since_nxt;
         src_r <= src_nxt;
         oe_r <= oe_nxt;
         thresh_r <= thresh_nxt;
         stamp_r <= stamp_nxt;
         level_r <= level_nxt;
         en_r <= en_nxt;
         status_r <= status_nxt;
         mode_r <= mode_nxt;
         pulse_out_r <= pulse_out_nxt;
         line_oe_r <= line_oe_nxt;
         arrived_r <= arrived_nxt;
         lost_r <= lost_nxt;
         found_r <= found_nxt;
         trig_evt_r <= trig_evt_nxt;
      end
   end

   // outputs straight from flops
   assign {awready, wready, arready} = {awready_r, wready_r, arready_r};
   assign {bvalid, bresp} = {bvalid_r, bresp_r};
   assign {rvalid, rresp, rdata} = {rvalid_r, rresp_r, rdata_r};
   assign {shared_pulse_line_out, shared_pulse_line_oe} =
      {pulse_out_r, line_oe_r};
   assign pps_mode = mode_r;
   assign {pps_arrived_evt, pps_lost_evt, pps_found_evt} =
      {arrived_r, lost_r, found_r};
   assign gp_trigger_event = trig_evt_r;
endmodule : pps_sync_top

// ### pps_sync_pkg.sv
// What this block does
// - mode from source and line direction
// - lost external pulse reverts source internal
// - slave->free-run, sync master->master on loss
// - internal source: incoming pulse raises found
// - 16-bit acceptance threshold in subseconds
// - accept within 65535-th .. 65536+th
// - zero threshold accepts 65535..65536 only
// - threshold 65535 accepts all, never lost
// - arrived, lost and found events
// - separate event per enabled trigger
// - masters drive shared line every second
// - sync master aligns to sync input
// - slave aligns to shared line input
// - source 0 external, 1 internal, default internal
package pps_sync_pkg;
   // time base
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned SEC_NS = 1000000000;
   localparam int unsigned SUBSEC_PER_SEC = 65536;
   // rounds down: the second runs slightly fast
   localparam int unsigned SUBSEC_CYC = SEC_NS / (CLK_NS * SUBSEC_PER_SEC);
   localparam logic [10:0] SUBSEC_CYC_M1 = 11'(SUBSEC_CYC - 1);
   localparam logic [10:0] DIV_ZERO = 11'h000;
   localparam logic [15:0] SUBSEC_MAX = 16'hffff;
   localparam logic [15:0] THRESH_ALL = 16'hffff;
   localparam logic [15:0] THRESH_RESET = 16'h0000;
   localparam logic [17:0] SPAN_NOMINAL = 18'h0ffff;
   localparam logic [17:0] SPAN_NEXT = 18'h10000;
   localparam logic [17:0] SINCE_SAT = 18'h3ffff;
   localparam logic [15:0] PULSE_TICKS = 16'h0100;
   localparam int unsigned HALF_SEC_BIT = 15;
   localparam int unsigned N_TRIG = 8;
   localparam int unsigned N_PINS = N_TRIG + 2;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_SEC = 8'h08;
   localparam logic [7:0] OFS_SUBSEC = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_ARRIVE = 8'h14;
   localparam logic [7:0] OFS_TRIG_LEVEL = 8'h18;
   localparam logic [7:0] OFS_TRIG_EN = 8'h1c;
   // fields
   localparam int unsigned CTRL_SRC_BIT = 0;
   localparam int unsigned CTRL_OE_BIT = 1;
   localparam logic SRC_EXTERNAL = 1'b0;
   localparam logic SRC_INTERNAL = 1'b1;
   localparam logic OE_RESET = 1'b0;
   localparam int unsigned ST_ARRIVED = 0;
   localparam int unsigned ST_LOST = 1;
   localparam int unsigned ST_FOUND = 2;
   localparam int unsigned ST_TRIG_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0]
   {
      MODE_FREE_RUN,
      MODE_MASTER,
      MODE_SYNC_MASTER,
      MODE_SLAVE
   } mode_t;
endpackage : pps_sync_pkg

// ### pin_sync2.sv
`timescale 1ns/10ps
module pin_sync2 #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule : pin_sync2

// ### edge_detect.sv
`timescale 1ns/10ps
module edge_detect #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // synchronised levels in, edge pulses out
   input wire logic [W-1:0] d,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev_r;

   // previous sample; reset low so a high pin gives one rise
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev_r <= '0;
      else
         prev_r <= d;
   end

   assign rise = d & ~prev_r;
   assign fall = ~d & prev_r;
endmodule : edge_detect

// ### pps_sync_top_monitor.sv
`timescale 1ns/10ps
module pps_sync_top_monitor
   import pps_sync_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write response
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // pulse line
   input wire logic shared_pulse_line_out,
   input wire logic shared_pulse_line_oe,
   // mode and events
   input wire mode_t pps_mode,
   input wire logic pps_arrived_evt,
   input wire logic pps_lost_evt,
   input wire logic pps_found_evt,
   input wire logic [N_TRIG-1:0] gp_trigger_event
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic drv;
   logic ext;
   // mode groups: driving the line, following an outside pulse
   assign drv = pps_mode == MODE_MASTER || pps_mode == MODE_SYNC_MASTER;
   assign ext = pps_mode == MODE_SLAVE || pps_mode == MODE_SYNC_MASTER;
   a_mode_dir: assert property (
      $stable(shared_pulse_line_oe) |-> drv == shared_pulse_line_oe)
      else $error("mode disagrees with line direction");
   a_line_idle: assert property (
      !shared_pulse_line_oe |-> !shared_pulse_line_out)
      else $error("line pulsed while not driving");
   a_lost_fall: assert property (pps_lost_evt |-> ##[0:2] !ext)
      else $error("source stayed external after loss");
   a_lost_drive: assert property (
      pps_lost_evt && shared_pulse_line_oe |=> shared_pulse_line_oe [*2])
      else $error("driving stopped after loss");
   a_found_int: assert property (pps_found_evt |-> !$past(ext))
      else $error("found event under external source");
   a_arr_ext: assert property (pps_arrived_evt |-> $past(ext))
      else $error("arrived event under internal source");
   a_evt_excl: assert property (
      $onehot0({pps_arrived_evt, pps_lost_evt, pps_found_evt}))
      else $error("two pulse events at once");
   a_arr_pulse: assert property (pps_arrived_evt |=> !pps_arrived_evt)
      else $error("arrived event longer than one cycle");
   a_trig_pulse: assert property (
      (gp_trigger_event & $past(gp_trigger_event)) == '0)
      else $error("trigger event longer than one cycle");
   // response held until taken
   a_resp_hold: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   // main scenarios reached
   c_arrived: cover property (pps_arrived_evt);
   c_lost: cover property (pps_lost_evt);
   c_found: cover property (pps_found_evt);
   c_trig: cover property (|gp_trigger_event);
endmodule : pps_sync_top_monitor

bind pps_sync_top pps_sync_top_monitor i_pps_sync_top_monitor (
   .aclk, .aresetn, .bresp, .bvalid, .bready,
   .shared_pulse_line_out, .shared_pulse_line_oe, .pps_mode,
   .pps_arrived_evt, .pps_lost_evt, .pps_found_evt, .gp_trigger_event
);

// ### pulse_peer.sv
`timescale 1ns/10ps
module pulse_peer (
   // clock
   input wire logic aclk,
   // pulse requests
   input wire logic fire_shared,
   input wire logic fire_sync,
   // device side of shared line
   input wire logic dev_out,
   input wire logic dev_oe,
   // resolved pin levels
   output logic shared_level,
   output logic sync_level
);
   logic [4:0] sh_r = 5'h00;
   logic [4:0] sy_r = 5'h00;
   // each request makes a 16 cycle high pulse
   always_ff @(posedge aclk)
   begin
      sh_r <= fire_shared ? 5'h10 : sh_r - 5'(sh_r != 5'h00);
      sy_r <= fire_sync ? 5'h10 : sy_r - 5'(sy_r != 5'h00);
   end
   // peer keeps off while the device drives; pull-down when idle
   assign shared_level = dev_oe ? dev_out : (sh_r != 5'h00);
   assign sync_level = sy_r != 5'h00;
endmodule : pulse_peer

// ### tb_pps_sync_top.sv
`timescale 1ns/10ps
module tb_pps_sync_top;
   import pps_sync_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic fire_sh = 1'b0;
   logic fire_sy = 1'b0;
   logic sh_lvl;
   logic sy_lvl;
   logic line_out;
   logic line_oe;
   logic [N_TRIG-1:0] trig_in = '0;
   logic [N_TRIG-1:0] trig_evt;
   logic [N_TRIG-1:0] trig_seen = '0;
   mode_t pps_mode;
   logic arr_evt;
   logic lost_evt;
   logic found_evt;
   int n_arr = 0;
   int n_lost = 0;
   int n_found = 0;
   int errors = 0;
   int compares = 0;
   mode_t exp_m [4] = '{MODE_SLAVE, MODE_FREE_RUN, MODE_SYNC_MASTER,
      MODE_MASTER};

   always #5 aclk = ~aclk;

   pps_sync_top i_pps_sync_top (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sync_in_line(sy_lvl), .shared_pulse_line_in(sh_lvl),
      .shared_pulse_line_out(line_out), .shared_pulse_line_oe(line_oe),
      .gp_trigger_in(trig_in), .pps_mode(pps_mode),
      .pps_arrived_evt(arr_evt), .pps_lost_evt(lost_evt),
      .pps_found_evt(found_evt), .gp_trigger_event(trig_evt));
   pulse_peer i_pulse_peer (.aclk(aclk), .fire_shared(fire_sh),
      .fire_sync(fire_sy), .dev_out(line_out), .dev_oe(line_oe),
      .shared_level(sh_lvl), .sync_level(sy_lvl));

   // event tally mid-cycle, where the one-cycle pulses have settled
   always @(negedge aclk)
   begin
      if (aresetn)
      begin
         n_arr += int'(arr_evt === 1'b1);
         n_lost += int'(lost_evt === 1'b1);
         n_found += int'(found_evt === 1'b1);
         trig_seen |= trig_evt;
      end
   end

   task automatic end_of_test();
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // a wait that runs out ends the run
   task automatic bound(input int n);
      if (n >= 200)
      begin
         errors++;
         end_of_test();
      end
   endtask : bound

   // ready is looked at mid-cycle, the item moves at the next edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      logic ta;
      logic tw;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      n = 0;
      while (!(ta && tw))
      begin
         @(negedge aclk);
         ta |= awready === 1'b1;
         tw |= wready === 1'b1;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         n++;
         bound(n);
      end
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
         bound(n);
      end
      while (bvalid !== 1'b1);
      check({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      int n;
      logic ta;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ta = 1'b0;
      n = 0;
      while (!ta)
      begin
         @(negedge aclk);
         ta = arready === 1'b1;
         @(posedge aclk);
         n++;
         bound(n);
      end
      arvalid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
         bound(n);
      end
      while (rvalid !== 1'b1);
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      rready <= 1'b0;
   endtask : axi_read

   // one peer pulse on the sync pin or the shared line
   task automatic pulse(input logic sy);
      @(posedge aclk);
      fire_sy <= sy;
      fire_sh <= !sy;
      @(posedge aclk);
      fire_sy <= 1'b0;
      fire_sh <= 1'b0;
      repeat (40) @(posedge aclk);
   endtask : pulse

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(OFS_CTRL, 32'h1, RESP_OKAY);
      axi_read(OFS_THRESH, 32'h0, RESP_OKAY);
      axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
      check(32'(pps_mode), 32'(MODE_FREE_RUN));
      axi_read(8'h20, 32'h0, RESP_SLVERR);
      axi_write(8'h24, 32'h5, RESP_SLVERR);
      axi_write(OFS_THRESH, 32'(THRESH_ALL), RESP_OKAY);
      axi_read(OFS_THRESH, 32'hffff, RESP_OKAY);
      for (int c = 0; c < 4; c++)
      begin
         axi_write(OFS_CTRL, 32'(c), RESP_OKAY);
         repeat (2) @(posedge aclk);
         check(32'(pps_mode), 32'(exp_m[c]));
         check(32'(line_oe), 32'(c[1]));
         check(32'(line_out), 32'(c[1]));
      end
      for (int k = 0; k < 2; k++)
      begin
         axi_write(OFS_CTRL, k ? 32'h2 : 32'h0, RESP_OKAY);
         pulse(k[0]);
         check(n_arr, k + 1);
         check(32'(pps_mode), 32'(exp_m[k * 2]));
      end
      check(n_lost, 0);
      axi_write(OFS_CTRL, 32'h1, RESP_OKAY);
      repeat (2) pulse(1'b0);
      check(n_found, 2);
      check(n_arr, 2);
      axi_read(OFS_STATUS, 32'h5, RESP_OKAY);
      axi_write(OFS_STATUS, 32'h5, RESP_OKAY);
      axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
      axi_write(OFS_THRESH, 32'h0, RESP_OKAY);
      for (int k = 0; k < 2; k++)
      begin
         axi_write(OFS_CTRL, k ? 32'h2 : 32'h0, RESP_OKAY);
         pulse(k[0]);
         check(n_lost, k + 1);
         check(32'(pps_mode), 32'(exp_m[k * 2 + 1]));
         axi_read(OFS_CTRL, k ? 32'h3 : 32'h1, RESP_OKAY);
      end
      check(n_arr + n_found, 4);
      axi_write(OFS_TRIG_EN, 32'h7f, RESP_OKAY);
      axi_write(OFS_TRIG_LEVEL, 32'h0f, RESP_OKAY);
      @(posedge aclk);
      trig_in <= '1;
      repeat (10) @(posedge aclk);
      check(32'(trig_seen), 32'h70);
      trig_in <= '0;
      repeat (10) @(posedge aclk);
      check(32'(trig_seen), 32'h7f);
      axi_read(OFS_STATUS, 32'h7f02, RESP_OKAY);
      axi_read(OFS_TRIG_EN, 32'h7f, RESP_OKAY);
      // counter writes add; the run ends before the first subsecond tick
      axi_write(OFS_SEC, 32'hfffffffb, RESP_OKAY);
      axi_write(OFS_SEC, 32'ha, RESP_OKAY);
      axi_write(OFS_SUBSEC, 32'h10, RESP_OKAY);
      axi_read(OFS_SEC, 32'h5, RESP_OKAY);
      axi_read(OFS_SUBSEC, 32'h10, RESP_OKAY);
      // master on internal source: sync pin pulse is found and stamped
      pulse(1'b1);
      check(n_found, 3);
      axi_read(OFS_ARRIVE, 32'h00050010, RESP_OKAY);
      end_of_test();
   end

   // overall limit on run length
   initial
   begin
      repeat (100000) @(posedge aclk);
      errors++;
      end_of_test();
   end
endmodule : tb_pps_sync_top
